// ===== inc/umsag_params.svh
// Offsets, field positions, reset values and timing counts of the modem status and activity gate
`ifndef UMSAG_PARAMS_SVH
`define UMSAG_PARAMS_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define UMSAG_MLS_IDX        32'h0c000016
`define UMSAG_SCR_IDX        32'h0c000017
`define UMSAG_RST_IDX        32'h0c000019
`define UMSAG_MSK_IDX        32'h0c00001c
`define UMSAG_TMO_IDX        32'h0c00001e
`define UMSAG_BYTE_ADDR(idx) ((idx) << 2)

// ****************************************************************
// Field positions
// ****************************************************************
`define UMSAG_LEVEL_MSB      7
`define UMSAG_LEVEL_LSB      4
`define UMSAG_CHANGE_MSB     3
`define UMSAG_CHANGE_LSB     0
`define UMSAG_RST_BIT        0
`define UMSAG_MSK_RXD        5
`define UMSAG_MSK_RTS        4
`define UMSAG_MSK_DCD        3
`define UMSAG_MSK_DTR        2
`define UMSAG_MSK_RSVD       1
`define UMSAG_MSK_TXW        0
`define UMSAG_MSK_WRITABLE   8'h3d

// ****************************************************************
// Reset values
// ****************************************************************
`define UMSAG_RST_RESET      8'h00
`define UMSAG_MSK_RESET      8'h00
`define UMSAG_TMO_RESET      8'h00
`define UMSAG_SCR_RESET      8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define UMSAG_CLK_PERIOD_PS  40000
`define UMSAG_TICK_PS        30500000
`define UMSAG_TICK_CYCLES    (`UMSAG_TICK_PS / `UMSAG_CLK_PERIOD_PS)

`endif

// ===== inc/umsag_pkg.sv
// Types shared by the modem status and activity gate
package umsag_pkg;
    typedef logic [1:0] umsag_resp_type;
    localparam umsag_resp_type UMSAG_RESP_OKAY   = 2'h0;
    localparam umsag_resp_type UMSAG_RESP_SLVERR = 2'h2;
    typedef enum logic {UMSAG_CLK_RUN, UMSAG_CLK_STOP} umsag_clk_state_type;
endpackage

// ===== design/umsag_top.sv
// Modem status, scratch, soft reset and activity clock gate behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "umsag_params.svh"

// Overview of operation
// - Status bits 7:4 show inverted input levels
// - Status bits 3:0 latch input level changes
// - Status read clears change flags that were set
// - Scratch byte is free, steers nothing
// - Reset bit forces unit reset, resets zero
// - Reserved reset and mask bits read zero
// - Mask bits per activity source, 1 masks
// - Masked sources never reach activity timer
// - Timeout is units of 30.5 us, zero disables
// - Any edge on the RXD, RTS, DCD or DTR line is activity
// - Transmit buffer writes also count as activity
// - Unmasked activity restarts the idle count
// - Full idle timeout stops serial core clock
// - Activity restores the stopped core clock
module umsag_top #(
    parameter int TICK_CYCLES = `UMSAG_TICK_CYCLES
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rstn,
    input  wire logic [31:0]               i_s_axi_awaddr,
    input  wire logic                      i_s_axi_awvalid,
    output logic                           o_s_axi_awready,
    input  wire logic [31:0]               i_s_axi_wdata,
    input  wire logic [3:0]                i_s_axi_wstrb,
    input  wire logic                      i_s_axi_wvalid,
    output logic                           o_s_axi_wready,
    output umsag_pkg::umsag_resp_type      o_s_axi_bresp,
    output logic                           o_s_axi_bvalid,
    input  wire logic                      i_s_axi_bready,
    input  wire logic [31:0]               i_s_axi_araddr,
    input  wire logic                      i_s_axi_arvalid,
    output logic                           o_s_axi_arready,
    output logic [31:0]                    o_s_axi_rdata,
    output umsag_pkg::umsag_resp_type      o_s_axi_rresp,
    output logic                           o_s_axi_rvalid,
    input  wire logic                      i_s_axi_rready,
    input  wire logic                      i_carrier_detect_in_n,
    input  wire logic                      i_ring_indicate_in_n,
    input  wire logic                      i_data_set_ready_in_n,
    input  wire logic                      i_clear_to_send_in_n,
    input  wire logic                      i_serial_receive_in,
    input  wire logic                      i_request_to_send_line_n,
    input  wire logic                      i_terminal_ready_line_n,
    input  wire logic                      i_tx_buf_write,
    output logic                           o_serial_core_clock_en,
    output logic                           o_force_unit_reset
);
    import umsag_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [3:0]          modem_now_reg;
    logic [3:0]          modem_prev_reg;
    logic [3:0]          modem_change;
    logic [3:0]          change_flags_reg;
    logic [3:0]          watch_now_reg;
    logic [3:0]          watch_prev_reg;
    logic [3:0]          watch_edge;
    logic                tx_write_reg;
    logic [7:0]          scratch_value_reg;
    logic [7:0]          unit_soft_reset_reg;
    logic [7:0]          activity_source_mask_reg;
    logic [7:0]          idle_timeout_units_reg;
    logic [7:0]          idle_count_reg;
    logic [7:0]          idle_count_next;
    logic [15:0]         tick_div_reg;
    logic                tick;
    logic                activity;
    umsag_clk_state_type clk_state_reg;
    logic                wr_fire;
    logic                rd_fire;
    logic                wr_take;
    logic                rd_take;
    logic                mls_read;
    logic [31:0]         rd_value;
    logic                rd_hit;
    logic                wr_hit;
    logic [7:0]          wbyte;

    localparam logic [31:0] MLS_ADDR = `UMSAG_BYTE_ADDR(`UMSAG_MLS_IDX);
    localparam logic [31:0] SCR_ADDR = `UMSAG_BYTE_ADDR(`UMSAG_SCR_IDX);
    localparam logic [31:0] RST_ADDR = `UMSAG_BYTE_ADDR(`UMSAG_RST_IDX);
    localparam logic [31:0] MSK_ADDR = `UMSAG_BYTE_ADDR(`UMSAG_MSK_IDX);
    localparam logic [31:0] TMO_ADDR = `UMSAG_BYTE_ADDR(`UMSAG_TMO_IDX);

    // ****************************************************************
    // Bus handshakes
    // ****************************************************************
    // Ready pulses first; response only follows both handshakes
    assign wr_fire  = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_awready && !o_s_axi_bvalid;
    assign wr_take  = o_s_axi_awready && i_s_axi_awvalid && o_s_axi_wready && i_s_axi_wvalid;
    assign rd_fire  = i_s_axi_arvalid && !o_s_axi_arready && !o_s_axi_rvalid;
    assign rd_take  = o_s_axi_arready && i_s_axi_arvalid;
    assign mls_read = rd_take && (i_s_axi_araddr == MLS_ADDR);
    assign wbyte    = i_s_axi_wdata[7:0];
    assign wr_hit   = (i_s_axi_awaddr == SCR_ADDR) || (i_s_axi_awaddr == RST_ADDR)
                   || (i_s_axi_awaddr == MSK_ADDR) || (i_s_axi_awaddr == TMO_ADDR)
                   || (i_s_axi_awaddr == MLS_ADDR);

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready  <= 1'b0;
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_bresp   <= UMSAG_RESP_OKAY;
        end else begin
            o_s_axi_awready <= wr_fire;
            o_s_axi_wready  <= wr_fire;
            if (wr_take) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_hit ? UMSAG_RESP_OKAY : UMSAG_RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rd_value = 32'h0;
        rd_hit   = 1'b1;
        case (i_s_axi_araddr)
            MLS_ADDR: rd_value[7:0] = {~modem_now_reg, change_flags_reg};
            SCR_ADDR: rd_value[7:0] = scratch_value_reg;
            RST_ADDR: rd_value[7:0] = unit_soft_reset_reg;
            MSK_ADDR: rd_value[7:0] = activity_source_mask_reg;
            TMO_ADDR: rd_value[7:0] = idle_timeout_units_reg;
            default:  rd_hit        = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rdata   <= 32'h0;
            o_s_axi_rresp   <= UMSAG_RESP_OKAY;
        end else begin
            o_s_axi_arready <= rd_fire;
            if (rd_take) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata  <= rd_value;
                o_s_axi_rresp  <= rd_hit ? UMSAG_RESP_OKAY : UMSAG_RESP_SLVERR;
            end else if (i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    // Scratch steers nothing; it only stores
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            scratch_value_reg <= `UMSAG_SCR_RESET;
        end else if (wr_take && i_s_axi_wstrb[0] && i_s_axi_awaddr == SCR_ADDR) begin
            scratch_value_reg <= wbyte;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            unit_soft_reset_reg    <= `UMSAG_RST_RESET;
            o_force_unit_reset     <= 1'b0;
        end else if (wr_take && i_s_axi_wstrb[0] && i_s_axi_awaddr == RST_ADDR) begin
            unit_soft_reset_reg    <= {7'h0, wbyte[`UMSAG_RST_BIT]};
            o_force_unit_reset     <= wbyte[`UMSAG_RST_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            activity_source_mask_reg <= `UMSAG_MSK_RESET;
            idle_timeout_units_reg   <= `UMSAG_TMO_RESET;
        end else if (wr_take && i_s_axi_wstrb[0]) begin
            if (i_s_axi_awaddr == MSK_ADDR) begin
                // Bit 1 dropped even if software breaks its zero-write duty
                activity_source_mask_reg <= wbyte & `UMSAG_MSK_WRITABLE;
            end
            if (i_s_axi_awaddr == TMO_ADDR) begin
                idle_timeout_units_reg <= wbyte;
            end
        end
    end

    // ****************************************************************
    // Modem status
    // ****************************************************************
    // Core clock never stops here, so edges during a gated period are kept
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            modem_now_reg  <= 4'hf;
            modem_prev_reg <= 4'hf;
            watch_now_reg  <= 4'hf;
            watch_prev_reg <= 4'hf;
            tx_write_reg   <= 1'b0;
        end else begin
            modem_now_reg  <= {i_carrier_detect_in_n, i_ring_indicate_in_n,
                               i_data_set_ready_in_n, i_clear_to_send_in_n};
            modem_prev_reg <= modem_now_reg;
            watch_now_reg  <= {i_serial_receive_in, i_request_to_send_line_n,
                               i_carrier_detect_in_n, i_terminal_ready_line_n};
            watch_prev_reg <= watch_now_reg;
            tx_write_reg   <= i_tx_buf_write;
        end
    end

    assign modem_change = modem_now_reg ^ modem_prev_reg;
    assign watch_edge   = watch_now_reg ^ watch_prev_reg;

    // Set wins over the read clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            change_flags_reg <= 4'h0;
        end else begin
            change_flags_reg <= (change_flags_reg & ~{4{mls_read}}) | modem_change;
        end
    end

    // ****************************************************************
    // Activity timer and clock gate
    // ****************************************************************
    assign activity = (watch_edge[3] && !activity_source_mask_reg[`UMSAG_MSK_RXD])
                   || (watch_edge[2] && !activity_source_mask_reg[`UMSAG_MSK_RTS])
                   || (watch_edge[1] && !activity_source_mask_reg[`UMSAG_MSK_DCD])
                   || (watch_edge[0] && !activity_source_mask_reg[`UMSAG_MSK_DTR])
                   || (tx_write_reg && !activity_source_mask_reg[`UMSAG_MSK_TXW]);

    assign tick = (tick_div_reg == 16'(TICK_CYCLES - 1));

    // Divider restarts with activity so a period is exactly N ticks
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn || activity || tick) begin
            tick_div_reg <= 16'h0;
        end else begin
            tick_div_reg <= tick_div_reg + 16'h1;
        end
    end

    always_comb begin
        idle_count_next = idle_count_reg;
        if (activity) begin
            idle_count_next = 8'h0;
        end else if (tick && idle_count_reg < idle_timeout_units_reg) begin
            idle_count_next = idle_count_reg + 8'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            idle_count_reg <= 8'h0;
        end else begin
            idle_count_reg <= idle_count_next;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            clk_state_reg          <= UMSAG_CLK_RUN;
            o_serial_core_clock_en <= 1'b1;
        end else begin
            case (clk_state_reg)
                UMSAG_CLK_RUN: begin
                    if (!activity && idle_timeout_units_reg != 8'h0
                        && idle_count_next >= idle_timeout_units_reg) begin
                        clk_state_reg          <= UMSAG_CLK_STOP;
                        o_serial_core_clock_en <= 1'b0;
                    end
                end
                UMSAG_CLK_STOP: begin
                    if (activity || idle_timeout_units_reg == 8'h0) begin
                        clk_state_reg          <= UMSAG_CLK_RUN;
                        o_serial_core_clock_en <= 1'b1;
                    end
                end
                default: begin
                    clk_state_reg          <= UMSAG_CLK_RUN;
                    o_serial_core_clock_en <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_level_readback: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        mls_read |=> o_s_axi_rdata[7:4] == ~$past(modem_now_reg))
        else $error("level bits not inverted inputs");
    a_change_sets: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (|modem_change) |=> (change_flags_reg & $past(modem_change)) == $past(modem_change))
        else $error("change flag not set");
    a_read_clears: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (mls_read && modem_change == 4'h0) |=> change_flags_reg == 4'h0)
        else $error("read did not clear flags");
    a_scratch_stable: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !(wr_take && i_s_axi_awaddr == SCR_ADDR) |=> $stable(scratch_value_reg))
        else $error("scratch changed without write");
    a_reset_follows: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (wr_take && i_s_axi_wstrb[0] && i_s_axi_awaddr == RST_ADDR)
        |=> o_force_unit_reset == $past(i_s_axi_wdata[0]))
        else $error("forced reset not following write");
    a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        unit_soft_reset_reg[7:1] == 7'h0 && activity_source_mask_reg[7:6] == 2'h0)
        else $error("reserved bits not zero");
    a_mask_bit1_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !activity_source_mask_reg[`UMSAG_MSK_RSVD])
        else $error("mask bit 1 not zero");
    a_masked_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (tx_write_reg && activity_source_mask_reg[`UMSAG_MSK_TXW] && watch_edge == 4'h0)
        |-> !activity)
        else $error("masked write reported");
    a_wake_restart: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        activity |=> o_serial_core_clock_en && idle_count_reg == 8'h0 && tick_div_reg == 16'h0)
        else $error("activity did not restart");
    a_timeout_stop: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (idle_timeout_units_reg != 8'h0 && idle_count_reg >= idle_timeout_units_reg
         && !activity) |=> !o_serial_core_clock_en)
        else $error("clock not stopped after timeout");
    a_disabled_runs: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        idle_timeout_units_reg == 8'h0 |=> o_serial_core_clock_en)
        else $error("clock stopped while timer disabled");
    a_stop_holds: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (!o_serial_core_clock_en && !activity && idle_timeout_units_reg != 8'h0)
        |=> !o_serial_core_clock_en)
        else $error("clock restarted without activity");
endmodule

// ===== tb/umsag_modem_model.sv
// Behavioural modem peripheral driving the monitored control lines
`timescale 1ns/1ps
module umsag_modem_model (
    input  wire logic i_clk,
    output logic      o_carrier_n,
    output logic      o_ring_n,
    output logic      o_set_ready_n,
    output logic      o_clear_to_send_n,
    output logic      o_receive,
    output logic      o_request_n,
    output logic      o_terminal_ready_n
);
    // ****************************************************************
    // Line driver
    // ****************************************************************
    // Idle at the inactive level, so reset sees no stray change
    initial begin
        {o_carrier_n, o_ring_n, o_set_ready_n, o_clear_to_send_n} = 4'hf;
        {o_receive, o_request_n, o_terminal_ready_n} = 3'h7;
    end
    // Lines move on an edge by nonblocking update, so that edge still samples the old levels
    task automatic drive(input logic [6:0] v);
        @(posedge i_clk);
        {o_carrier_n, o_ring_n, o_set_ready_n, o_clear_to_send_n} <= v[6:3];
        {o_receive, o_request_n, o_terminal_ready_n} <= v[2:0];
    endtask
endmodule

// ===== tb/tb_uart_modem_status_activity_gate.sv
// Self-checking bench for the modem status and activity gate
`timescale 1ns/1ps
`include "umsag_params.svh"
module tb_uart_modem_status_activity_gate;
    import umsag_pkg::*;
    // ****************************************************************
    // Signals and model state
    // ****************************************************************
    localparam int T = 4;
    localparam logic [31:0] A_MLS = `UMSAG_MLS_IDX * 4;
    localparam logic [31:0] A_SCR = `UMSAG_SCR_IDX * 4;
    localparam logic [31:0] A_RST = `UMSAG_RST_IDX * 4;
    localparam logic [31:0] A_MSK = `UMSAG_MSK_IDX * 4;
    localparam logic [31:0] A_TMO = `UMSAG_TMO_IDX * 4;
    localparam logic [31:0] A_BAD = 32'h30000060;
    logic           clk;
    logic           rstn;
    logic [31:0]    awaddr, wdata, araddr, rd, rdata;
    logic [3:0]     wstrb;
    logic           awvalid, wvalid, bready, arvalid, rready, txw;
    logic           awready, wready, bvalid, arready, rvalid, clk_en, frst;
    umsag_resp_type bresp, rresp, resp;
    wire            dcd_n, ri_n, dsr_n, cts_n, rxd, rts_n, dtr_n;
    int             num_errors = 0;
    int             checked = 0;
    int             n;
    logic [7:0]     lfsr = 8'h08;
    logic [7:0]     scr;
    logic [7:0]     v;
    logic [6:0]     lines = 7'h7f;
    logic [3:0]     flags = 4'h0;
    int             msk_bit[5] = '{5, 4, 3, 2, 0};
    int             line_bit[5] = '{2, 1, 6, 0, 0};

    umsag_modem_model modem (.i_clk(clk), .o_carrier_n(dcd_n), .o_ring_n(ri_n),
        .o_set_ready_n(dsr_n), .o_clear_to_send_n(cts_n), .o_receive(rxd),
        .o_request_n(rts_n), .o_terminal_ready_n(dtr_n));

    umsag_top #(.TICK_CYCLES(T)) uut (.i_core_clk(clk), .i_rstn(rstn),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .i_carrier_detect_in_n(dcd_n), .i_ring_indicate_in_n(ri_n),
        .i_data_set_ready_in_n(dsr_n), .i_clear_to_send_in_n(cts_n),
        .i_serial_receive_in(rxd), .i_request_to_send_line_n(rts_n),
        .i_terminal_ready_line_n(dtr_n), .i_tx_buf_write(txw),
        .o_serial_core_clock_en(clk_en), .o_force_unit_reset(frst));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] next_rand();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    task automatic end_sim();
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Holds each channel until its own ready, no fixed latency assumed
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        $display("[FAIL] %0t ns: write hung", $time);
        num_errors++;
    endtask

    task automatic axi_rd(input logic [31:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        $display("[FAIL] %0t ns: read hung", $time);
        num_errors++;
    endtask

    // Model latches every level change of the four status lines
    task automatic set_lines(input logic [6:0] nv);
        flags = flags | (lines[6:3] ^ nv[6:3]);
        lines = nv;
        modem.drive(nv);
        tick(3);
    endtask

    task automatic fire(input int s);
        if (s == 4) begin
            @(posedge clk);
            txw <= 1'b1;
            @(posedge clk);
            txw <= 1'b0;
        end else begin
            set_lines(lines ^ (7'h01 << line_bit[s]));
        end
    endtask

    task automatic wait_en(input logic lv, input int mx);
        n = 0;
        while (clk_en !== lv && n < mx) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic chk_resets();
        axi_rd(A_RST);
        chk(rd, 32'h0);
        axi_rd(A_MSK);
        chk(rd, 32'h0);
        axi_rd(A_TMO);
        chk(rd, 32'h0);
        chk(resp, UMSAG_RESP_OKAY);
        chk(clk_en, 1'b1);
        chk(frst, 1'b0);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {awaddr, wdata, araddr, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready, txw, rstn} = '0;
        tick(10);
        rstn <= 1'b1;
        chk_resets();
        for (int i = 0; i < 3; i++) begin
            v = next_rand();
            scr = next_rand();
            axi_wr(A_SCR, {v, v, v, scr}, 4'hf);
            axi_wr(A_SCR, {24'h0, v}, 4'h0);
            axi_rd(A_SCR);
            chk(rd, {24'h0, scr});
            chk(frst, 1'b0);
        end
        axi_wr(A_RST, 32'hff, 4'hf);
        axi_rd(A_RST);
        chk(rd, 32'h1);
        chk(frst, 1'b1);
        axi_wr(A_RST, 32'h0, 4'hf);
        chk(frst, 1'b0);
        // Bit 1 kept at zero by software, reserved top bits still tried
        axi_wr(A_MSK, 32'hfd, 4'hf);
        axi_rd(A_MSK);
        chk(rd, 32'h3d);
        axi_wr(A_BAD, 32'h5a, 4'hf);
        chk(resp, UMSAG_RESP_SLVERR);
        axi_rd(A_BAD);
        chk(resp, UMSAG_RESP_SLVERR);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = next_rand();
            set_lines({v[3:0], lines[2:0]});
            axi_rd(A_MLS);
            chk(rd, {24'h0, ~lines[6:3], flags});
            flags = 4'h0;
            axi_rd(A_MLS);
            chk(rd, {24'h0, ~lines[6:3], 4'h0});
        end
        // Late transmit write must restart a nearly expired count
        axi_wr(A_MSK, 32'h0, 4'hf);
        axi_wr(A_TMO, 32'h2, 4'hf);
        fire(0);
        tick(4);
        chk(clk_en, 1'b1);
        fire(4);
        wait_en(1'b0, 40);
        chk(n >= 2 * T - 2 && n <= 2 * T + 4, 1'b1);
        axi_wr(A_TMO, 32'h1, 4'hf);
        for (int s = 0; s < 5; s++) begin
            axi_wr(A_MSK, 32'h1 << msk_bit[s], 4'hf);
            wait_en(1'b0, 40);
            chk(clk_en, 1'b0);
            fire(s);
            tick(6);
            chk(clk_en, 1'b0);
            axi_wr(A_MSK, 32'h0, 4'hf);
            fire(s);
            wait_en(1'b1, 4);
            chk(clk_en, 1'b1);
            // Opposite direction of the same line, or a second transmit write, must wake as well
            wait_en(1'b0, 40);
            fire(s);
            wait_en(1'b1, 4);
            chk(clk_en, 1'b1);
        end
        wait_en(1'b0, 40);
        axi_wr(A_TMO, 32'h0, 4'hf);
        tick(2);
        chk(clk_en, 1'b1);
        tick(30);
        chk(clk_en, 1'b1);
        axi_rd(A_MLS);
        chk(rd, {24'h0, ~lines[6:3], flags});
        axi_wr(A_RST, 32'h1, 4'hf);
        axi_wr(A_MSK, 32'h3d, 4'hf);
        axi_wr(A_TMO, 32'h5, 4'hf);
        @(posedge clk);
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        chk_resets();
        end_sim();
    end

    // Whole run needs well under a tenth of this span
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end
endmodule
